// *** rcm_channel.sv ***
// one output channel: on/off decision, clamp lock and overload latch
`default_nettype none
module rcm_channel
    import rcm_pkg::*;
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic dev_rst,
    input wire logic [1:0] mode,
    input wire logic pin_mode,
    input wire logic pin_level,
    input wire logic clamp,
    input wire logic overload,
    output logic gate_on,
    output logic diag,
    output logic ovl_event
);
    logic [CNT_W-1:0] ovl_cnt;
    logic want_on;
    logic trip;

    // pin high means on, low means off; off or clear always wins
    assign want_on = (mode == RCM_ON) && (!pin_mode || pin_level) // RL6 RL7
        && !diag; // RL17
    assign trip = gate_on && overload
        && (ovl_cnt == CNT_W'(OVL_CYCLES - 1));

    // ========================================
    // gate: a fresh turn-on waits out any clamping still in progress
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            gate_on <= 1'b0;
        end else if (clk_en) begin
            if (dev_rst) begin
                gate_on <= 1'b0; // RL9
            end else begin
                gate_on <= want_on && !trip
                    && (gate_on || !clamp); // RL11
            end
        end
    end

    // overload must persist the full delay before the channel trips
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ovl_cnt <= '0;
        end else if (clk_en) begin
            if (dev_rst || !gate_on || !overload) begin
                ovl_cnt <= '0;
            end else if (!trip) begin
                ovl_cnt <= ovl_cnt + CNT_W'(1); // RL16
            end
        end
    end

    // diagnosis latch holds the channel off until clear mode is set
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            diag <= 1'b0;
            ovl_event <= 1'b0;
        end else if (clk_en) begin
            ovl_event <= trip && !dev_rst;
            if (dev_rst) begin
                diag <= 1'b0;
            end else if (trip) begin
                diag <= 1'b1; // RL16
            end else if (mode == RCM_CLR) begin
                diag <= 1'b0; // RL16
            end
        end
    end
endmodule // rcm_channel
`default_nettype wire

// *** rcm_host_pins.sv ***
// host side model of the control pins and the reset pin
`default_nettype none
module rcm_host_pins
    import rcm_pkg::*;
(
    input wire logic [NPIN-1:0] pin_req,
    input wire logic [NPIN-1:0] pin_open,
    input wire logic rst_req,
    output logic [NPIN-1:0] control_pin,
    output logic reset_pin_n
);
    timeunit 1ns;
    timeprecision 1ps;
    // an open pin is pulled to ground by the sink, never left floating
    assign control_pin = pin_req & ~pin_open;
    // reset pin low for as long as the host asks
    assign reset_pin_n = !rst_req;
endmodule // rcm_host_pins
`default_nettype wire

// *** rcm_monitor.sv ***
// port checker for the relay channel mode control
`default_nettype none
module rcm_monitor
    import rcm_pkg::*;
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic reset_pin_n,
    input wire logic supply_ok,
    input wire logic [NCH-1:0] clamp_active,
    input wire logic [NCH-1:0] overload_raw,
    input wire logic [NCH-1:0] gate_on,
    input wire logic low_power
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    // ========================================
    // overload run on channel 0 while it conducts
    int ovl_run;
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ovl_run <= 0;
        end else if (overload_raw[0] && gate_on[0]) begin
            ovl_run <= ovl_run + 1;
        end else begin
            ovl_run <= 0;
        end
    end
    // ========================================
    // bus, reset and output relations
    apb_ready_a: assert property (psel && penable |-> pready)
        else $error("access phase without ready");
    bad_addr_a: assert property (psel && !penable && paddr == 8'hFC
        |=> pslverr) else $error("unmapped access not refused");
    wr_rdata_a: assert property (psel && !penable && pwrite
        |=> prdata == 32'h0) else $error("read data not zero on write");
    pin_reset_a: assert property ((!reset_pin_n)[*8]
        |-> low_power && gate_on == '0)
        else $error("reset pin did not force defaults");
    supply_reset_a: assert property ((!supply_ok)[*8]
        |-> low_power && gate_on == '0)
        else $error("low supply did not force reset");
    reset_wr_err_a: assert property ((!reset_pin_n)[*8] ##0
        (psel && !penable && pwrite) |=> pslverr)
        else $error("write in reset not refused");
    standby_off_a: assert property (low_power |-> gate_on == '0)
        else $error("gate on while in low power");
    ovl_limit_a: assert property (ovl_run <= OVL_CYCLES + 8)
        else $error("overload did not trip channel 0");
    for (genvar i = 0; i < NCH; i++) begin : g_clamp
        clamp_hold_a: assert property (clamp_active[i][*6] ##0
            !gate_on[i] |=> !gate_on[i])
            else $error("turn on during clamping");
    end
endmodule // rcm_monitor
bind rcm_top rcm_monitor u_mon (.clock(clock), .rst_n(rst_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .reset_pin_n(reset_pin_n), .supply_ok(supply_ok),
    .clamp_active(clamp_active), .overload_raw(overload_raw),
    .gate_on(gate_on), .low_power(low_power));
`default_nettype wire

// *** rcm_pin_sync.sv ***
// three-flop synchroniser that accepts a change once two stages agree
`default_nettype none
module rcm_pin_sync
    import rcm_pkg::*;
#(
    parameter int W = 1
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    logic [W-1:0] stage1;
    logic [W-1:0] stage2;
    logic [W-1:0] stage3;

    // ========================================
    // stage1 feeds stage2 only; reset low reads as a pulled-down pin
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            stage1 <= '0;
            stage2 <= '0;
            stage3 <= '0;
        end else if (clk_en) begin
            stage1 <= async_in;
            stage2 <= stage1;
            stage3 <= stage2;
        end
    end

    // per bit: take the new level only while stage2 and stage3 agree
    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            always_ff @(posedge clock or negedge rst_n) begin
                if (!rst_n) begin
                    sync_out[i] <= 1'b0;
                end else if (clk_en && (stage2[i] == stage3[i])) begin
                    sync_out[i] <= stage3[i];
                end
            end
        end
    endgenerate
endmodule // rcm_pin_sync
`default_nettype wire

// *** rcm_pkg.sv ***
// constants and types shared by the relay channel mode control
`default_nettype none
package rcm_pkg;
    // ========================================
    // channel and pin counts
    localparam int NCH = 8;
    localparam int NPIN = 4;
    localparam int SEL_W = 2;
    // ========================================
    // channel mode codes, code 3 is illegal
    typedef enum logic [1:0] {
        RCM_OFF = 2'h0,
        RCM_ON = 2'h1,
        RCM_CLR = 2'h2
    } rcm_mode_t;
    // ========================================
    // register map, byte addresses on apb
    localparam int ADDR_W = 8;
    localparam logic [7:0] REG_MODE = 8'h00;
    localparam logic [7:0] REG_SRC = 8'h04;
    localparam logic [7:0] REG_STAT = 8'h08;
    localparam logic [7:0] REG_INT_STAT = 8'h0C;
    localparam logic [7:0] REG_INT_MASK = 8'h10;
    // reset values: every channel off, serial source
    localparam logic [15:0] MODE_RST = 16'h0000;
    localparam logic [23:0] SRC_RST = 24'h000000;
    localparam logic [9:0] MASK_RST = 10'h000;
    // field positions
    localparam int SRC_PIN_LSB = 8;
    localparam int STAT_DIAG_LSB = 8;
    localparam int STAT_STBY_BIT = 16;
    localparam int STAT_RST_BIT = 17;
    localparam int INT_RST_BIT = 8;
    localparam int INT_STBY_BIT = 9;
    localparam int INT_W = 10;
    // ========================================
    // timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int OVL_DELAY_NS = 10000;
    localparam int OVL_CYCLES =
        (OVL_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W = $clog2(OVL_CYCLES + 1);
    // supply comparator trip level behind supply_ok, in millivolts
    localparam int POR_THRESHOLD_MV = 4000;
endpackage : rcm_pkg
`default_nettype wire

// *** rcm_top.sv ***
// relay channel mode control with apb registers and interrupt
//
// Notes on behaviour
// RL1: supply start-up leaves every channel in OFF
// RL2: host sets Clear once per channel after start-up
// RL3: reset pin low forces defaults, minimum current
// RL4: all channels Clear enters low-power standby
// RL5: four control pins, per-channel pin selection
// RL6: serial bits or selected pin drive transistor
// RL7: pin high means ON, pin low OFF
// RL8: open control pin reads low, channel off
// RL9: any reset: channels OFF, outputs held cleared
// RL10: host: OFF, wait wake-up, then ON
// RL11: turn-on refused until clamping has ended
// RL12: power-on reset while supply under threshold
// RL13: host standby wake-up wait at least 200 ms
// RL14: host holds reset pin low 50 us
// RL15: host allows 200 us after reset release
// RL16: overload trips channel, latched until Clear
// RL17: per-channel mode and source; OFF/Clear gate off
//
// The register offsets and the APB register port were decided locally.
`default_nettype none
module rcm_top
    import rcm_pkg::*;
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic clk_en,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // pins and analog status
    input wire logic [NPIN-1:0] control_pin,
    input wire logic reset_pin_n,
    input wire logic supply_ok,
    input wire logic [NCH-1:0] clamp_active,
    input wire logic [NCH-1:0] overload_raw,
    // outputs
    output logic [NCH-1:0] gate_on,
    output logic low_power,
    output logic irq
);
    localparam int SW = NPIN + 2 + 2 * NCH;

    logic [SW-1:0] raw_in;
    logic [SW-1:0] synced;
    logic [NPIN-1:0] pin_lvl;
    logic reset_pin_ok;
    logic supply_ok_s;
    logic [NCH-1:0] clamp_s;
    logic [NCH-1:0] ovl_s;
    logic dev_rst;
    logic dev_rst_q;
    logic [15:0] mode_reg;
    logic [23:0] src_reg;
    logic [INT_W-1:0] int_stat;
    logic [INT_W-1:0] int_mask;
    logic [INT_W-1:0] int_set;
    logic [NCH-1:0] diag;
    logic [NCH-1:0] ovl_event;
    logic [NCH-1:0] ch_clear;
    logic all_clear;
    logic all_clear_q;
    logic setup;
    logic wr_en;
    logic addr_ok;
    logic [31:0] rd_word;

    // ========================================
    // field decode helpers, shared by several blocks
    function automatic logic [1:0] mode_of(
        input logic [15:0] m,
        input int ch
    );
        mode_of = m[2*ch +: 2];
    endfunction

    function automatic logic [SEL_W-1:0] pin_of(
        input logic [23:0] s,
        input int ch
    );
        pin_of = s[SRC_PIN_LSB + SEL_W*ch +: SEL_W];
    endfunction

    function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
        is_mapped = (a == REG_MODE) || (a == REG_SRC)
            || (a == REG_STAT) || (a == REG_INT_STAT)
            || (a == REG_INT_MASK);
    endfunction

    // ========================================
    // input synchronisers
    // every pin and analog flag comes from outside this clock
    assign raw_in = {overload_raw, clamp_active, supply_ok,
        reset_pin_n, control_pin};

    rcm_pin_sync #(
        .W(SW)
    ) u_sync (
        .clock(clock),
        .rst_n(rst_n),
        .clk_en(clk_en),
        .async_in(raw_in),
        .sync_out(synced)
    );

    // synced bits start low: a floating pin looks like an off request
    assign pin_lvl = synced[NPIN-1:0]; // RL8
    assign reset_pin_ok = synced[NPIN];
    assign supply_ok_s = synced[NPIN+1];
    assign clamp_s = synced[NPIN+2 +: NCH];
    assign ovl_s = synced[NPIN+2+NCH +: NCH];

    // ========================================
    // device reset
    // supply below the trip level acts like the reset pin held low
    assign dev_rst = !reset_pin_ok // RL3
        || !supply_ok_s; // RL12

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            dev_rst_q <= 1'b1;
        end else if (clk_en) begin
            dev_rst_q <= dev_rst;
        end
    end

    // ========================================
    // standby detection
    genvar c;
    generate
        for (c = 0; c < NCH; c++) begin : g_clr
            assign ch_clear[c] = (mode_of(mode_reg, c) == RCM_CLR);
        end
    endgenerate

    assign all_clear = &ch_clear; // RL4

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            all_clear_q <= 1'b0;
        end else if (clk_en) begin
            all_clear_q <= all_clear;
        end
    end

    // power stages go quiet in reset and in all-clear standby
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            low_power <= 1'b1;
        end else if (clk_en) begin
            low_power <= dev_rst // RL3
                || all_clear; // RL4
        end
    end

    // ========================================
    // apb access decode
    // zero wait states: read data is latched during setup
    assign setup = psel && !penable;
    assign wr_en = psel && penable && pwrite && !pslverr;
    assign pready = 1'b1;
    assign addr_ok = is_mapped(paddr) && !pwrite
        || is_mapped(paddr) && !dev_rst;

    // ========================================
    // mode register, two bits per channel
    // illegal code 3 keeps the previous mode of that channel
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            mode_reg <= MODE_RST; // RL1
        end else if (clk_en) begin
            if (dev_rst) begin
                mode_reg <= MODE_RST; // RL9
            end else if (wr_en && paddr == REG_MODE) begin
                for (int i = 0; i < NCH; i++) begin
                    if (mode_of(pwdata[15:0], i) != 2'h3) begin
                        mode_reg[2*i +: 2] <= // RL17
                            mode_of(pwdata[15:0], i);
                    end
                end
            end
        end
    end

    // ========================================
    // source register: input mode bits and pin selectors
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            src_reg <= SRC_RST;
        end else if (clk_en) begin
            if (dev_rst) begin
                src_reg <= SRC_RST; // RL3
            end else if (wr_en && paddr == REG_SRC) begin
                src_reg <= pwdata[23:0]; // RL5
            end
        end
    end

    // ========================================
    // interrupt mask
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            int_mask <= MASK_RST;
        end else if (clk_en) begin
            if (dev_rst) begin
                int_mask <= MASK_RST; // RL3
            end else if (wr_en && paddr == REG_INT_MASK) begin
                int_mask <= pwdata[INT_W-1:0];
            end
        end
    end

    // ========================================
    // interrupt status, write one to clear
    // kept through device reset so software can see it happened
    always_comb begin
        int_set = '0;
        int_set[NCH-1:0] = ovl_event;
        int_set[INT_RST_BIT] = dev_rst && !dev_rst_q;
        int_set[INT_STBY_BIT] = all_clear && !all_clear_q;
    end

    // a set in the same cycle as its clear wins
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            int_stat <= '0;
        end else if (clk_en) begin
            if (wr_en && paddr == REG_INT_STAT) begin
                int_stat <= (int_stat & ~pwdata[INT_W-1:0])
                    | int_set;
            end else begin
                int_stat <= int_stat | int_set;
            end
        end
    end

    assign irq = |(int_stat & int_mask);

    // ========================================
    // read mux
    always_comb begin
        rd_word = 32'h00000000;
        unique case (paddr)
            REG_MODE: rd_word[15:0] = mode_reg;
            REG_SRC: rd_word[23:0] = src_reg;
            REG_STAT: begin
                rd_word[NCH-1:0] = gate_on;
                rd_word[STAT_DIAG_LSB +: NCH] = diag;
                rd_word[STAT_STBY_BIT] = all_clear;
                rd_word[STAT_RST_BIT] = dev_rst;
            end
            REG_INT_STAT: rd_word[INT_W-1:0] = int_stat;
            REG_INT_MASK: rd_word[INT_W-1:0] = int_mask;
            default: rd_word = 32'h00000000;
        endcase
    end

    // read data and error are captured at setup, shown in access
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            prdata <= 32'h00000000;
            pslverr <= 1'b0;
        end else if (clk_en) begin
            if (setup) begin
                prdata <= pwrite ? 32'h00000000 : rd_word;
                pslverr <= !addr_ok;
            end else if (!psel) begin
                pslverr <= 1'b0;
            end
        end
    end

    // ========================================
    // channel instances
    generate
        for (c = 0; c < NCH; c++) begin : g_ch
            logic sel_level;
            // pin chosen by this channel's selector
            assign sel_level = pin_lvl[pin_of(src_reg, c)]; // RL5

            rcm_channel u_ch (
                .clock(clock),
                .rst_n(rst_n),
                .clk_en(clk_en),
                .dev_rst(dev_rst),
                .mode(mode_of(mode_reg, c)),
                .pin_mode(src_reg[c]),
                .pin_level(sel_level),
                .clamp(clamp_s[c]),
                .overload(ovl_s[c]),
                .gate_on(gate_on[c]),
                .diag(diag[c]),
                .ovl_event(ovl_event[c])
            );
        end
    endgenerate
endmodule // rcm_top
`default_nettype wire

// *** relay_channel_mode_control_test.sv ***
// self-checking bench for the relay channel mode control
`default_nettype none
module relay_channel_mode_control_test;
    import rcm_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock, rst_n, psel, penable, pwrite, pready, pslverr, e, ce;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, q, s;
    logic [15:0] m;
    logic [NPIN-1:0] pin_req, pin_open, control_pin, pr, po;
    logic rst_req, reset_pin_n, supply_ok, low_power, irq;
    logic [NCH-1:0] clamp_active, overload_raw, gate_on, g;
    int error_cnt, n_checks, seed;
    rcm_top u_dut (.clock(clock), .rst_n(rst_n), .clk_en(ce),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .control_pin(control_pin),
        .reset_pin_n(reset_pin_n), .supply_ok(supply_ok),
        .clamp_active(clamp_active), .overload_raw(overload_raw),
        .gate_on(gate_on), .low_power(low_power), .irq(irq));
    rcm_host_pins u_host (.pin_req(pin_req), .pin_open(pin_open),
        .rst_req(rst_req), .control_pin(control_pin),
        .reset_pin_n(reset_pin_n));
    // ========================================
    // clock and watchdog
    initial begin
        clock = 0;
        forever #5 clock = ~clock;
    end
    initial begin
        repeat (20000) @(posedge clock);
        error_cnt++;
        end_of_test();
    end
    // ========================================
    // helpers
    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
    endtask
    task automatic chk(input string nm, input logic [31:0] ex,
            input logic [31:0] got);
        n_checks++;
        if (got !== ex) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", nm, ex, got);
        end
    endtask
    // one apb transfer, held until ready is sampled high
    task automatic apb(input logic wr, input logic [7:0] a,
            input logic [31:0] d);
        @(posedge clock);
        psel <= 1;
        penable <= 0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1;
        // no cycle budget here: only the watchdog may end a hung wait
        do begin
            @(posedge clock);
        end while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 0;
        penable <= 0;
    endtask
    function automatic logic [7:0] exp_ser(input logic [15:0] md);
        for (int i = 0; i < NCH; i++) exp_ser[i] = md[2*i+:2] == 2'h1;
    endfunction
    function automatic logic [7:0] exp_pin(input logic [3:0] p);
        for (int i = 0; i < NCH; i++) exp_pin[i] = p[i%4];
    endfunction
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // ========================================
    // main sequence
    initial begin
        seed = 4;
        error_cnt = 0;
        n_checks = 0;
        {rst_n, psel, penable, pwrite, paddr, pwdata} = '0;
        {pin_req, pin_open, rst_req, clamp_active, overload_raw} = '0;
        supply_ok = 1;
        ce = 1;
        cyc(3);
        rst_n <= 1;
        cyc(6);
        apb(0, REG_MODE, 0);
        chk("mode rst", 0, q);
        apb(0, REG_SRC, 0);
        chk("src rst", 0, q);
        apb(0, 8'hFC, 0);
        chk("unmapped", 1, e);
        // host clears every channel once, then leaves standby by OFF
        apb(1, REG_MODE, 32'hAAAA);
        cyc(2);
        chk("standby", 1, low_power);
        apb(1, REG_MODE, 0);
        cyc(4);
        chk("standby exit", 0, low_power);
        $display("test defaults done");
        repeat (6) begin
            m = 16'($random(seed)) & 16'h5555;
            apb(1, REG_MODE, 32'(m));
            cyc(2);
            chk("serial gate", 32'(exp_ser(m)), 32'(gate_on));
        end
        apb(1, REG_MODE, 32'hFFFF);
        cyc(2);
        chk("code 3", 32'(exp_ser(m)), 32'(gate_on));
        // clock enable low: the write is lost and the gates stay put
        ce <= 0;
        apb(1, REG_MODE, 0);
        cyc(2);
        chk("frozen", 32'(exp_ser(m)), 32'(gate_on));
        ce <= 1;
        $display("test serial done");
        s = 0;
        for (int i = 0; i < NCH; i++) begin
            s[i] = 1;
            s[SRC_PIN_LSB+2*i+:2] = 2'(i % 4);
        end
        apb(1, REG_SRC, s);
        apb(1, REG_MODE, 32'h5555);
        repeat (8) begin
            pr = 4'($random(seed));
            po = 4'($random(seed));
            pin_req <= pr;
            pin_open <= po;
            cyc(6);
            chk("pin gate", 32'(exp_pin(pr & ~po)), 32'(gate_on));
        end
        apb(1, REG_MODE, 0);
        cyc(2);
        chk("pin off", 0, 32'(gate_on));
        apb(1, REG_SRC, 0);
        $display("test pins done");
        clamp_active <= 8'h02;
        cyc(2);
        apb(1, REG_MODE, 32'h4);
        cyc(8);
        chk("clamp hold", 0, 32'(gate_on));
        clamp_active <= 0;
        cyc(6);
        chk("clamp end", 2, 32'(gate_on));
        $display("test clamp done");
        apb(1, REG_INT_MASK, 1);
        apb(1, REG_MODE, 1);
        cyc(2);
        chk("irq idle", 0, 32'(irq));
        overload_raw <= 8'h01;
        cyc(OVL_CYCLES + 8);
        chk("ovl trip", 0, 32'(gate_on));
        chk("irq set", 1, 32'(irq));
        overload_raw <= 0;
        apb(0, REG_STAT, 0);
        chk("stat diag", 32'h1 << STAT_DIAG_LSB, q);
        apb(0, REG_INT_STAT, 0);
        chk("ovl stat", 32'h1 | (32'h1 << INT_STBY_BIT), q);
        apb(1, REG_INT_STAT, 1);
        cyc(1);
        chk("irq clr", 0, 32'(irq));
        apb(1, REG_MODE, 0);
        apb(1, REG_MODE, 1);
        cyc(2);
        chk("ovl latched", 0, 32'(gate_on));
        apb(1, REG_MODE, 2);
        apb(1, REG_MODE, 0);
        apb(1, REG_MODE, 1);
        cyc(2);
        chk("ovl reon", 1, 32'(gate_on));
        $display("test overload done");
        // reset pin, then low supply; hold is shortened for the run
        for (int k = 0; k < 2; k++) begin
            apb(1, REG_MODE, 1);
            apb(1, REG_INT_STAT, 32'h3FF);
            if (k == 0) begin
                rst_req <= 1;
            end else begin
                supply_ok <= 0;
            end
            cyc(8);
            chk("rst lowpwr", 1, 32'(low_power));
            chk("rst gate", 0, 32'(gate_on));
            apb(1, REG_MODE, 1);
            chk("rst wr err", 1, 32'(e));
            rst_req <= 0;
            supply_ok <= 1;
            cyc(8);
            apb(0, REG_MODE, 0);
            chk("mode dflt", 0, q);
            apb(0, REG_INT_STAT, 0);
            chk("rst stat", 1, 32'(q[INT_RST_BIT]));
            chk("irq masked", 0, 32'(irq));
        end
        $display("test reset done");
        end_of_test();
    end
endmodule // relay_channel_mode_control_test
`default_nettype wire
